// ==== verilog/fan_regs_defs.vh ====
`ifndef FAN_REGS_DEFS_VH
`define FAN_REGS_DEFS_VH

// ----------------------------------------
// Command bytes
// ----------------------------------------
`define CMD_CONFIGURATION 8'h04
`define CMD_STATUS        8'h05
`define CMD_DUTY          8'h06
`define CMD_MAKER         8'h07

// ----------------------------------------
// Configuration fields
// ----------------------------------------
`define CFG_FAULT_CLEAR   7
`define CFG_RESOLUTION    6
`define CFG_DUTY_SOURCE   5
`define CFG_RSVD_ZERO     4
`define CFG_RSVD_ONE      3
`define CFG_PPR_HI        2
`define CFG_PPR_LO        1
`define CFG_SHUTDOWN      0

// ----------------------------------------
// Status fields
// ----------------------------------------
`define ST_OVER_TEMP      5
`define ST_OVERFLOW       3
`define ST_INPUT_OPEN     2
`define ST_FAN_FAULT      0

// ----------------------------------------
// Reset values
// ----------------------------------------
`define CFG_RESET         8'h0a
`define DUTY_RESET        4'h2
`define MAKER_CODE        8'ha5

// ----------------------------------------
// Speed scale and timing
// ----------------------------------------
`define SPEED_MAX_RPM     12775
`define FAULT_TIME_MS     2400
`define CLK_MHZ           125
`define FAULT_CYCLES      (`FAULT_TIME_MS * 1000 * `CLK_MHZ)
`define STRAP_LOAD        4'he
`define STRAP_DONE        4'hf

`endif

// ==== verilog/fan_ctrl_config_status_regs.v ====
`timescale 1ns/100ps
// Notes on behaviour
// [RQ1] Fault-clear write drops fan fault and alert
// [RQ2] Resolution bit picks 25 or 50 RPM steps
// [RQ3] Duty source one uses duty register
// [RQ4] Duty source zero follows temperature level
// [RQ5] Open input on analog source uses code 2
// [RQ6] Config bit4 reads zero, bit3 reads one
// [RQ7] Pulse field selects 1,2,4,8 pulses per turn
// [RQ8] Shutdown bit enters low-power mode
// [RQ9] Status read-only; bits 7,6,4,1 read zero
// [RQ10] Over-temp flag caught after power-up
// [RQ11] Overflow flag follows speed above 12775
// [RQ12] Input-open flag caught after power-up
// [RQ13] Fault sets flag and alert together
// [RQ14] Duty codes 0..15 span 30..100 percent
// [RQ15] Fixed read-only maker code
// [RQ16] Fault needs low speed over 2.4 s
// [RQ17] Command bytes 04,05,06 select registers
// [RQ18] Writes to read-only bits are ignored
`include "fan_regs_defs.vh"

module fan_ctrl_config_status_regs #(
    parameter [31:0] FAULT_CYCLES = `FAULT_CYCLES
) (
    input  wire        mclk,
    input  wire        rst_n,
    input  wire [7:0]  cmd,
    input  wire [7:0]  wdata,
    input  wire        wr_en,
    output reg  [7:0]  rdata,
    input  wire [13:0] speed_rpm,
    input  wire [7:0]  fault_threshold,
    input  wire [3:0]  temp_level,
    input  wire        temp_over_pin,
    input  wire        temp_open_pin,
    output reg  [3:0]  duty_code,
    output reg  [1:0]  pulses_per_rotation,
    output reg  [3:0]  pulse_divide,
    output reg         speed_resolution_select,
    output reg         low_power_shutdown,
    output reg         fault_alert_n
);

// ----------------------------------------
// Pin synchronisers
// ----------------------------------------
wire over_stable;
wire open_stable;

pin_sync #(
    .RESET_LEVEL (1'b0)
) u_over_sync (
    .mclk  (mclk),
    .rst_n (rst_n),
    .pin   (temp_over_pin),
    .level (over_stable)
);

pin_sync #(
    .RESET_LEVEL (1'b0)
) u_open_sync (
    .mclk  (mclk),
    .rst_n (rst_n),
    .pin   (temp_open_pin),
    .level (open_stable)
);

// ----------------------------------------
// Registers
// ----------------------------------------
reg        fan_fault_clear;
reg        duty_source_select;
reg [3:0]  duty_cycle_setting;
reg        over_temp_flag;
reg        speed_overflow_flag;
reg        input_open_flag;
reg        fan_fault_flag;
reg [3:0]  strap_wait;
reg [31:0] low_count;

// ----------------------------------------
// Speed compare
// ----------------------------------------
// Threshold is in 50 RPM units; 255 steps still fit in 14 bits
wire [13:0] threshold_rpm = {6'h0, fault_threshold} * 14'd50;

// ----------------------------------------
// Write decode
// ----------------------------------------
wire cfg_write  = wr_en && (cmd == `CMD_CONFIGURATION); // [RQ17]
wire duty_write = wr_en && (cmd == `CMD_DUTY);          // [RQ17]
wire clear_req  = cfg_write && wdata[`CFG_FAULT_CLEAR];
wire speed_low  = speed_rpm < threshold_rpm;
wire fault_hit  = speed_low && (low_count >= FAULT_CYCLES);

// ----------------------------------------
// Configuration and duty next state
// ----------------------------------------
reg       next_fault_clear;
reg       next_resolution;
reg       next_duty_source;
reg [1:0] next_ppr;
reg       next_shutdown;
reg [3:0] next_duty_setting;

// Bits 4 and 3 have no storage, so a write to them cannot disturb anything
always @*
begin
    next_fault_clear  = fan_fault_clear;
    next_resolution   = speed_resolution_select;
    next_duty_source  = duty_source_select;
    next_ppr          = pulses_per_rotation;
    next_shutdown     = low_power_shutdown;
    next_duty_setting = duty_cycle_setting;
    // Read-only status and maker writes fall through untouched
    if (cfg_write) // [RQ18]
    begin
        next_fault_clear = wdata[`CFG_FAULT_CLEAR];        // [RQ1]
        next_resolution  = wdata[`CFG_RESOLUTION];         // [RQ2]
        next_duty_source = wdata[`CFG_DUTY_SOURCE];        // [RQ3]
        next_ppr         = wdata[`CFG_PPR_HI:`CFG_PPR_LO]; // [RQ7]
        next_shutdown    = wdata[`CFG_SHUTDOWN];           // [RQ8]
    end
    if (duty_write)
        next_duty_setting = wdata[3:0]; // [RQ14]
end

// ----------------------------------------
// Power-up strap capture
// ----------------------------------------
reg [3:0] next_strap_wait;
reg       next_over_temp;
reg       next_input_open;

// Straps are caught once, after the synchronisers have settled; later pin
// changes are ignored until the next reset
always @*
begin
    next_strap_wait = strap_wait;
    next_over_temp  = over_temp_flag;
    next_input_open = input_open_flag;
    if (strap_wait != `STRAP_DONE)
        next_strap_wait = strap_wait + 4'h1;
    if (strap_wait == `STRAP_LOAD)
    begin
        next_over_temp  = over_stable; // [RQ10]
        next_input_open = open_stable; // [RQ12]
    end
end

always @(posedge mclk)
begin
    if (!rst_n)
    begin
        fan_fault_clear         <= 1'b0;
        speed_resolution_select <= 1'b0;
        duty_source_select      <= 1'b0;
        pulses_per_rotation     <= 2'h1;
        low_power_shutdown      <= 1'b0;
        duty_cycle_setting      <= `DUTY_RESET;
        over_temp_flag          <= 1'b0;
        input_open_flag         <= 1'b0;
        strap_wait              <= 4'h0;
    end
    else
    begin
        fan_fault_clear         <= next_fault_clear;
        speed_resolution_select <= next_resolution;
        duty_source_select      <= next_duty_source;
        pulses_per_rotation     <= next_ppr;
        low_power_shutdown      <= next_shutdown;
        duty_cycle_setting      <= next_duty_setting;
        strap_wait              <= next_strap_wait;
        over_temp_flag          <= next_over_temp;
        input_open_flag         <= next_input_open;
    end
end

// ----------------------------------------
// Fault timing and flags
// ----------------------------------------
reg [31:0] next_low_count;
reg        next_fault_flag;
reg        next_alert_n;

always @*
begin
    next_low_count  = low_count;
    next_fault_flag = fan_fault_flag;
    next_alert_n    = fault_alert_n;
    // Counter saturates so a long stall cannot wrap it
    if (!speed_low)
        next_low_count = 32'h0;
    else if (low_count <= FAULT_CYCLES)
        next_low_count = low_count + 32'h1; // [RQ16]
    // A new fault wins over a clear in the same cycle
    if (fault_hit)
    begin
        next_fault_flag = 1'b1; // [RQ13]
        next_alert_n    = 1'b0; // [RQ13]
    end
    else if (clear_req)
    begin
        next_fault_flag = 1'b0; // [RQ1]
        next_alert_n    = 1'b1; // [RQ1]
    end
end

always @(posedge mclk)
begin
    if (!rst_n)
    begin
        low_count           <= 32'h0;
        fan_fault_flag      <= 1'b0;
        fault_alert_n       <= 1'b1;
        speed_overflow_flag <= 1'b0;
    end
    else
    begin
        low_count           <= next_low_count;
        fan_fault_flag      <= next_fault_flag;
        fault_alert_n       <= next_alert_n;
        speed_overflow_flag <= (speed_rpm > `SPEED_MAX_RPM); // [RQ11]
    end
end

// ----------------------------------------
// Drive duty and divider
// ----------------------------------------
reg [3:0] next_duty_code;
reg [3:0] next_pulse_divide;

// Open input only matters on the analog path; the host path ignores it
always @*
begin
    next_duty_code = temp_level; // [RQ4]
    if (duty_source_select)
        next_duty_code = duty_cycle_setting; // [RQ3] [RQ14]
    else if (input_open_flag)
        next_duty_code = `DUTY_RESET;        // [RQ5]
    case (pulses_per_rotation) // [RQ7]
    2'h0:
        next_pulse_divide = 4'h1;
    2'h1:
        next_pulse_divide = 4'h2;
    2'h2:
        next_pulse_divide = 4'h4;
    default:
        next_pulse_divide = 4'h8;
    endcase
end

always @(posedge mclk)
begin
    if (!rst_n)
    begin
        duty_code    <= `DUTY_RESET;
        pulse_divide <= 4'h2;
    end
    else
    begin
        // Code 0 is 30 percent, 15 is 100 percent
        duty_code    <= next_duty_code;
        pulse_divide <= next_pulse_divide;
    end
end

// ----------------------------------------
// Read mux
// ----------------------------------------
reg [7:0] next_rdata;

// Unimplemented bits are constants here so nothing a host writes can
// show through on a read
wire [7:0] config_word = {fan_fault_clear, speed_resolution_select, duty_source_select,
                          1'b0, 1'b1, pulses_per_rotation, low_power_shutdown}; // [RQ6]
wire [7:0] status_word = {2'h0, over_temp_flag, 1'b0, speed_overflow_flag,
                          input_open_flag, 1'b0, fan_fault_flag}; // [RQ9]
wire [7:0] duty_word   = {4'h0, duty_cycle_setting};

always @*
begin
    case (cmd) // [RQ17]
    `CMD_CONFIGURATION:
        next_rdata = config_word;
    `CMD_STATUS:
        next_rdata = status_word;
    `CMD_DUTY:
        next_rdata = duty_word;
    `CMD_MAKER:
        next_rdata = `MAKER_CODE; // [RQ15]
    default:
        next_rdata = 8'h00;
    endcase
end

always @(posedge mclk)
begin
    if (!rst_n)
        rdata <= 8'h00;
    else
        rdata <= next_rdata;
end

endmodule

// ----------------------------------------
// Three-stage pin synchroniser
// ----------------------------------------
// A change is taken only once stages two and three agree, so a single
// metastable sample can never reach the strap capture
module pin_sync #(
    parameter [0:0] RESET_LEVEL = 1'b0
) (
    input  wire mclk,
    input  wire rst_n,
    input  wire pin,
    output reg  level
);

reg [2:0] stages;

always @(posedge mclk)
begin
    if (!rst_n)
    begin
        stages <= {3{RESET_LEVEL}};
        level  <= RESET_LEVEL;
    end
    else
    begin
        stages <= {stages[1:0], pin};
        if (stages[2] == stages[1])
            level <= stages[2];
    end
end

endmodule

// ==== sim/fan_regs_asserts.sv ====
`timescale 1ns/100ps
`include "fan_regs_defs.vh"
module fan_regs_asserts #(parameter [31:0] FAULT_CYCLES = 20) (
    input wire        mclk,
    input wire        rst_n,
    input wire [7:0]  cmd,
    input wire [7:0]  wdata,
    input wire        wr_en,
    input wire [7:0]  rdata,
    input wire [13:0] speed_rpm,
    input wire [7:0]  fault_threshold,
    input wire [3:0]  pulse_divide,
    input wire        speed_resolution_select,
    input wire        low_power_shutdown,
    input wire        fault_alert_n
);
    // ----
    // Own low-speed run count, so a short fault delay shows up
    // ----
    reg  [31:0] lc;
    wire        low = speed_rpm < fault_threshold * 50;
    wire        wcfg = wr_en && cmd == `CMD_CONFIGURATION;
    always @(posedge mclk)
        lc <= (!rst_n || !low) ? 32'h0 : lc + 32'h1;
    default clocking @(posedge mclk); endclocking
    default disable iff (!rst_n);
    chk_cfg_fields: assert property (wcfg
        |=> speed_resolution_select == $past(wdata[6]) && low_power_shutdown == $past(wdata[0]))
        else $error("cfg bits");
    chk_ppr_divide: assert property (wcfg
        |-> ##2 pulse_divide == (4'h1 << $past(wdata[2:1], 2))) else $error("divide");
    chk_cfg_fixed: assert property (cmd == `CMD_CONFIGURATION |=> rdata[4:3] == 2'b01)
        else $error("cfg fixed bits");
    chk_status_zero: assert property (cmd == `CMD_STATUS |=> (rdata & 8'hd2) == 8'h00)
        else $error("status unused");
    chk_maker_code: assert property (cmd == `CMD_MAKER |=> rdata == `MAKER_CODE)
        else $error("maker");
    chk_alert_flag: assert property (cmd == `CMD_STATUS
        |=> rdata[0] == !$past(fault_alert_n)) else $error("alert");
    chk_speed_over: assert property (cmd == `CMD_STATUS
        |=> rdata[3] == ($past(speed_rpm, 2) > `SPEED_MAX_RPM)) else $error("overflow");
    chk_fault_delay: assert property ($fell(fault_alert_n) |-> lc >= FAULT_CYCLES)
        else $error("fault early");
    chk_fault_clear: assert property (wcfg && wdata[7] && !low |=> fault_alert_n)
        else $error("clear");
    cover property ($fell(fault_alert_n));
    cover property (wr_en && cmd == `CMD_DUTY);
    cover property (cmd == `CMD_MAKER ##1 rdata == `MAKER_CODE);
endmodule
bind fan_ctrl_config_status_regs fan_regs_asserts #(.FAULT_CYCLES(FAULT_CYCLES)) u_chk (.*);

// ==== sim/smbus_host_model.sv ====
`timescale 1ns/100ps
module smbus_host_model (
    input  wire       mclk,
    output reg  [7:0] cmd = 8'h00,
    output reg  [7:0] wdata = 8'h00,
    output reg        wr_en = 1'b0,
    output reg        rd_vld = 1'b0
);
    // ----
    // Write data is scrambled after use so stale bytes are never trusted
    // ----
    task wr(input [7:0] c, d);
        @(posedge mclk);
        cmd <= c;
        wdata <= d;
        wr_en <= 1'b1;
        @(posedge mclk);
        wr_en <= 1'b0;
        wdata <= ~d;
    endtask
    task rd(input [7:0] c);
        @(posedge mclk);
        cmd <= c;
        @(posedge mclk);
        rd_vld <= 1'b1;
        @(posedge mclk);
        rd_vld <= 1'b0;
    endtask
endmodule

// ==== sim/testbench.sv ====
`timescale 1ns/100ps
module testbench;
    reg         mclk = 0, rst_n = 0, temp_over_pin = 1, temp_open_pin = 0;
    reg  [13:0] speed_rpm = 14'd3000;
    reg  [7:0]  fault_threshold = 8'h0a;
    reg  [3:0]  temp_level = 4'h9;
    wire [7:0]  cmd, wdata, rdata;
    wire        wr_en, rd_vld, speed_resolution_select, low_power_shutdown, fault_alert_n;
    wire [3:0]  duty_code, pulse_divide;
    wire [1:0]  pulses_per_rotation;
    integer     num_errors = 0, compares = 0, seed = 1345, i, n;
    reg  [7:0]  d;
    reg  [7:0]  q[$];
    always #4 mclk = ~mclk;
    smbus_host_model u_host (.*);
    fan_ctrl_config_status_regs #(.FAULT_CYCLES(20)) u_dut (.*);
    task chk(input string nm, input [7:0] s, e);
        compares++;
        if (s !== e)
        begin
            num_errors++;
            $display("[FAIL] %s exp %h got %h", nm, e, s);
        end
    endtask
    task rchk(input [7:0] c, e);
        q.push_back(e);
        u_host.rd(c);
    endtask
    task complete_run;
        $display("errors %0d compares %0d", num_errors, compares);
        if (num_errors == 0 && compares > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    // ----
    // Read results are matched in issue order
    // ----
    always @(posedge mclk)
        if (rd_vld === 1'b1)
            chk("rdata", rdata, q.pop_front());
    initial
    begin
        repeat (5) @(posedge mclk);
        rst_n <= 1;
        repeat (20) @(posedge mclk);
        rchk(8'h04, 8'h0a);
        rchk(8'h06, 8'h02);
        rchk(8'h09, 8'h00);
        u_host.wr(8'h07, 8'h00);
        u_host.wr(8'h05, 8'hff);
        rchk(8'h07, 8'ha5);
        rchk(8'h05, 8'h20);
        for (i = 0; i < 4; i++)
        begin
            u_host.wr(8'h04, 8'hf1 | 8'(i * 2));
            // Divider settles one edge after the field itself
            repeat (2) @(posedge mclk);
            chk("divide", {4'h0, pulse_divide}, 8'(1 << i));
            d = {4'h0, speed_resolution_select, low_power_shutdown, pulses_per_rotation};
            chk("cfg out", d, 8'h0c | 8'(i));
            rchk(8'h04, 8'he9 | 8'(i * 2));
        end
        repeat (4)
        begin
            d = $random(seed);
            u_host.wr(8'h06, {4'h0, d[3:0]});
            repeat (2) @(posedge mclk);
            chk("duty", {4'h0, duty_code}, {4'h0, d[3:0]});
        end
        u_host.wr(8'h04, 8'h00);
        temp_level <= 4'hc;
        repeat (3) @(posedge mclk);
        chk("duty", {4'h0, duty_code}, 8'h0c);
        speed_rpm <= 14'd12776;
        repeat (2) @(posedge mclk);
        rchk(8'h05, 8'h28);
        speed_rpm <= 14'd12775;
        repeat (2) @(posedge mclk);
        rchk(8'h05, 8'h20);
        speed_rpm <= 14'd100;
        for (n = 0; n < 40 && fault_alert_n !== 1'b0; n++)
            @(posedge mclk);
        chk("fault time", 8'(n > 20 && n < 24), 8'h01);
        if (n == 40)
            complete_run;
        rchk(8'h05, 8'h21);
        speed_rpm <= 14'd3000;
        u_host.wr(8'h04, 8'h80);
        @(posedge mclk);
        chk("alert", {7'h0, fault_alert_n}, 8'h01);
        rchk(8'h05, 8'h20);
        rst_n <= 0;
        temp_over_pin <= 0;
        temp_open_pin <= 1;
        repeat (5) @(posedge mclk);
        rst_n <= 1;
        repeat (20) @(posedge mclk);
        chk("duty", {4'h0, duty_code}, 8'h02);
        rchk(8'h05, 8'h04);
        complete_run;
    end
endmodule
